// File: core/wwd_watchdog.sv
/*
 window watchdog sequencer: power-up reset, lead time, closed and open windows.
 assumes osc_tick is a one-cycle pulse per oscillator period, synchronous to core_clk.
*/
`include "wwd_cfg.svh"
module wwd_watchdog #(
  parameter int NRES_CYC = `WWD_NRES_CYC,
  parameter int SHORT_CYC = `WWD_SHORT_CYC,
  parameter int OPEN_PIN_CYC = `WWD_OPEN_PIN_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic watchdog_trigger_n,
  input wire logic osc_tick,
  input wire wwd_pkg::wwd_pin_t wd_timing_resistor_pin,
  input wire wwd_pkg::wwd_mode_t mode,
  output logic reset_n_out,
  output logic reset_n_oe,
  output logic src_txd_high,
  output logic src_rxd_high,
  output wwd_pkg::wwd_state_t wd_state
);
  logic trig;
  wwd_pkg::wwd_core_t r, next_r;
  logic pin_fault;

  wwd_trig_filter u_filter (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .watchdog_trigger_n(watchdog_trigger_n),
    .trig_pulse(trig)
  );

  always_comb begin
    next_r = r;
    pin_fault = 1'b0;
    // broken timing pin: fixed fallback timeout without trigger
    if (wd_timing_resistor_pin != wwd_pkg::wwd_pin_ok && (r.state == wwd_pkg::wwd_lead
        || r.state == wwd_pkg::wwd_closed || r.state == wwd_pkg::wwd_open)) begin
      if (trig) begin
        next_r.pin_cnt = 24'h000000;
      end else if ((wd_timing_resistor_pin == wwd_pkg::wwd_pin_short && r.pin_cnt == 24'(SHORT_CYC - 1))
          || (wd_timing_resistor_pin == wwd_pkg::wwd_pin_open && r.pin_cnt == 24'(OPEN_PIN_CYC - 1))) begin
        pin_fault = 1'b1;
      end else begin
        next_r.pin_cnt = r.pin_cnt + 24'h000001;
      end
    end else begin
      next_r.pin_cnt = 24'h000000;
    end
    unique case (r.state)
      wwd_pkg::wwd_off: begin
        next_r.reset_n = 1'b1;
        if (mode.rxd_fall) begin
          next_r.state = wwd_pkg::wwd_lead;
          next_r.osc_cnt = 13'h0000;
        end
      end
      wwd_pkg::wwd_por: begin
        next_r.reset_n = 1'b0;
        if (r.cyc_cnt == 24'(NRES_CYC - 1) && !mode.uv_reset) begin
          next_r.state = wwd_pkg::wwd_lead;
          next_r.reset_n = 1'b1;
          next_r.osc_cnt = 13'h0000;
          next_r.cyc_cnt = 24'h000000;
        end else if (r.cyc_cnt != 24'(NRES_CYC - 1)) begin
          next_r.cyc_cnt = r.cyc_cnt + 24'h000001;
        end
      end
      wwd_pkg::wwd_lead: begin
        if (trig) begin
          next_r.state = wwd_pkg::wwd_closed;
          next_r.osc_cnt = 13'h0000;
        end else if (pin_fault || (osc_tick && r.osc_cnt == 13'(`WWD_LEAD_OSC - 1))) begin
          next_r.state = wwd_pkg::wwd_fault;
          next_r.cyc_cnt = 24'h000000;
        end else if (osc_tick) begin
          next_r.osc_cnt = r.osc_cnt + 13'h0001;
        end
      end
      wwd_pkg::wwd_closed: begin
        if (trig || pin_fault) begin
          next_r.state = wwd_pkg::wwd_fault;
          next_r.cyc_cnt = 24'h000000;
        end else if (osc_tick && r.osc_cnt == 13'(`WWD_CLOSED_OSC - 1)) begin
          next_r.state = wwd_pkg::wwd_open;
          next_r.osc_cnt = 13'h0000;
        end else if (osc_tick) begin
          next_r.osc_cnt = r.osc_cnt + 13'h0001;
        end
      end
      wwd_pkg::wwd_open: begin
        if (trig) begin
          next_r.state = wwd_pkg::wwd_closed;
          next_r.osc_cnt = 13'h0000;
        end else if (pin_fault || (osc_tick && r.osc_cnt == 13'(`WWD_OPEN_OSC - 1))) begin
          next_r.state = wwd_pkg::wwd_fault;
          next_r.cyc_cnt = 24'h000000;
        end else if (osc_tick) begin
          next_r.osc_cnt = r.osc_cnt + 13'h0001;
        end
      end
      wwd_pkg::wwd_fault: begin
        if (r.cyc_cnt == 24'(NRES_CYC - 1)) begin
          next_r.state = wwd_pkg::wwd_lead;
          next_r.osc_cnt = 13'h0000;
          next_r.cyc_cnt = 24'h000000;
        end else begin
          next_r.cyc_cnt = r.cyc_cnt + 24'h000001;
        end
      end
      default: next_r.state = wwd_pkg::wwd_por;
    endcase
    // fault pulse drives reset low, with source indication in fail-safe
    if (next_r.state == wwd_pkg::wwd_fault) begin
      next_r.reset_n = 1'b0;
      next_r.src_hi = mode.fail_safe;
    end else begin
      next_r.src_hi = 1'b0;
      if (next_r.state != wwd_pkg::wwd_por) begin
        next_r.reset_n = 1'b1;
      end
    end
    if (!mode.fail_safe) begin
      next_r.src_hi = 1'b0;
    end
    // undervoltage restarts power-up reset; low power halts timing
    if (mode.uv_reset && r.state != wwd_pkg::wwd_por) begin
      next_r.state = wwd_pkg::wwd_por;
      next_r.cyc_cnt = 24'h000000;
      next_r.reset_n = 1'b0;
    end else if (mode.low_power) begin
      next_r.state = wwd_pkg::wwd_off;
      next_r.osc_cnt = 13'h0000;
      next_r.cyc_cnt = 24'h000000;
      next_r.pin_cnt = 24'h000000;
      next_r.reset_n = 1'b1;
      next_r.src_hi = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r <= '{state: wwd_pkg::wwd_por, osc_cnt: 13'h0000, cyc_cnt: 24'h000000,
             pin_cnt: 24'h000000, reset_n: 1'b0, src_hi: 1'b0};
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign reset_n_out = 1'b0;
  assign reset_n_oe = ~r.reset_n;
  assign src_txd_high = r.src_hi;
  assign src_rxd_high = r.src_hi;
  assign wd_state = r.state;
endmodule // wwd_watchdog

// File: core/wwd_cfg.svh
/*
 window watchdog constants: timing counts and pulse widths.
 assumes core_clk at 25 MHz and an oscillator tick input from the rc oscillator.
*/
`ifndef WWD_CFG_SVH
`define WWD_CFG_SVH
`define WWD_CLK_HZ 25000000
`define WWD_TRIG_MIN_NS 200
`define WWD_TRIG_MIN_CYC ((`WWD_TRIG_MIN_NS * 25 + 999) / 1000 + 1)
`define WWD_LEAD_OSC 7895
`define WWD_CLOSED_OSC 1053
`define WWD_OPEN_OSC 1105
`define WWD_NRES_MS 4
`define WWD_NRES_CYC (`WWD_NRES_MS * (`WWD_CLK_HZ / 1000))
`define WWD_SHORT_MS 90
`define WWD_OPEN_PIN_MS 390
`define WWD_SHORT_CYC (`WWD_SHORT_MS * (`WWD_CLK_HZ / 1000))
`define WWD_OPEN_PIN_CYC (`WWD_OPEN_PIN_MS * (`WWD_CLK_HZ / 1000))
`endif

// File: core/wwd_pkg.sv
/*
 window watchdog types.
 assumes wwd_cfg.svh is compiled alongside.
*/
package wwd_pkg;
  typedef enum logic [2:0] {
    wwd_off, wwd_por, wwd_lead, wwd_closed, wwd_open, wwd_fault
  } wwd_state_t;
  typedef enum logic [1:0] {
    wwd_pin_ok, wwd_pin_short, wwd_pin_open
  } wwd_pin_t;
  typedef struct packed {
    logic low_power;
    logic uv_reset;
    logic rxd_fall;
    logic fail_safe;
  } wwd_mode_t;
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [3:0] low_cnt;
    logic armed;
    logic trig;
  } wwd_flt_t;
  typedef struct packed {
    wwd_state_t state;
    logic [12:0] osc_cnt;
    logic [23:0] cyc_cnt;
    logic [23:0] pin_cnt;
    logic reset_n;
    logic src_hi;
  } wwd_core_t;
endpackage

// File: core/wwd_trig_filter.sv
/*
 trigger input synchroniser and glitch filter; one pulse per qualified low pulse.
 assumes trigger pin driven by the host, clocked by core_clk.
*/
`include "wwd_cfg.svh"
module wwd_trig_filter (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic watchdog_trigger_n,
  output logic trig_pulse
);
  wwd_pkg::wwd_flt_t r, next_r;
  always_comb begin
    next_r = r;
    next_r.sync1 = watchdog_trigger_n;
    next_r.sync2 = r.sync1;
    next_r.trig = 1'b0;
    if (r.sync2) begin
      next_r.low_cnt = 4'h0;
      next_r.armed = 1'b1;
    end else if (r.armed) begin
      // count low time, fire once it exceeds minimum
      if (r.low_cnt == 4'(`WWD_TRIG_MIN_CYC - 1)) begin
        next_r.trig = 1'b1;
        next_r.armed = 1'b0;
      end else begin
        next_r.low_cnt = r.low_cnt + 4'h1;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r <= '{sync1: 1'b1, sync2: 1'b1, low_cnt: 4'h0, armed: 1'b0, trig: 1'b0};
    end else if (clk_en) begin
      r <= next_r;
    end
  end
  assign trig_pulse = r.trig;
endmodule // wwd_trig_filter

// File: verif/wwd_props.sv
/* watchdog port checker.
 assumes binding to wwd_watchdog, clk_en kept high. */
module wwd_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire wwd_pkg::wwd_mode_t mode,
  input wire logic reset_n_out,
  input wire logic reset_n_oe,
  input wire logic src_txd_high,
  input wire logic src_rxd_high,
  input wire wwd_pkg::wwd_state_t wd_state
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_out_low; reset_n_out == 1'b0; endproperty
  a_out_low: assert property (p_out_low) else $error("reset data not low");
  property p_fault_oe; $rose(wd_state == wwd_pkg::wwd_fault) |-> ##[0:1] reset_n_oe; endproperty
  a_fault_oe: assert property (p_fault_oe) else $error("fault without reset");
  property p_oe_hold; $rose(reset_n_oe) |-> reset_n_oe [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("reset pulse short");
  property p_lp; mode.low_power && !mode.uv_reset |=> wd_state == wwd_pkg::wwd_off; endproperty
  a_lp: assert property (p_lp) else $error("not off in low power");
  property p_uv; mode.uv_reset |=> wd_state == wwd_pkg::wwd_por; endproperty
  a_uv: assert property (p_uv) else $error("undervoltage ignored");
  property p_src; src_txd_high |-> src_rxd_high && reset_n_oe; endproperty
  a_src: assert property (p_src) else $error("source pins wrong");
  property p_closed;
    $past(wd_state) == wwd_pkg::wwd_closed && wd_state != wwd_pkg::wwd_closed
      |-> wd_state inside {wwd_pkg::wwd_open, wwd_pkg::wwd_fault, wwd_pkg::wwd_off, wwd_pkg::wwd_por};
  endproperty
  a_closed: assert property (p_closed) else $error("bad closed exit");
  property p_wake; $past(wd_state) == wwd_pkg::wwd_off && wd_state == wwd_pkg::wwd_lead |-> $past(mode.rxd_fall); endproperty
  a_wake: assert property (p_wake) else $error("lead without wake");
endmodule // wwd_props
bind wwd_watchdog wwd_props u_props (.core_clk(core_clk), .sys_rst(sys_rst), .mode(mode),
  .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe), .src_txd_high(src_txd_high),
  .src_rxd_high(src_rxd_high), .wd_state(wd_state));

// File: verif/wwd_host.sv
/* host trigger model.
 assumes core_clk as its time base. */
module wwd_host (
  input wire logic core_clk,
  output logic trig_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial trig_n = 1'b1;
  task automatic pulse(input int n);
    repeat (n) @(negedge core_clk) trig_n = 1'b0;
    @(negedge core_clk) trig_n = 1'b1;
  endtask
endmodule // wwd_host

// File: verif/testbench.sv
/* watchdog testbench.
 assumes an oscillator tick every second cycle. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic osc_tick = 1'b0;
  logic reset_n_out, reset_n_oe, src_txd_high, src_rxd_high, trig_n;
  wwd_pkg::wwd_mode_t mode = '0;
  logic clk_en = 1'b1;
  wwd_pkg::wwd_pin_t pin = wwd_pkg::wwd_pin_ok;
  wwd_pkg::wwd_state_t wd_state;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  always #20 core_clk = ~core_clk;
  always @(negedge core_clk) osc_tick <= ~osc_tick;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      stop_test();
    end
  end
  wwd_host host (.core_clk(core_clk), .trig_n(trig_n));
  wwd_watchdog #(.NRES_CYC(20), .SHORT_CYC(200), .OPEN_PIN_CYC(400)) uut (.core_clk(core_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .watchdog_trigger_n(trig_n), .osc_tick(osc_tick),
    .wd_timing_resistor_pin(pin), .mode(mode), .reset_n_out(reset_n_out),
    .reset_n_oe(reset_n_oe), .src_txd_high(src_txd_high), .src_rxd_high(src_rxd_high), .wd_state(wd_state));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_st(input wwd_pkg::wwd_state_t st);
    n = 0;
    while (wd_state !== st && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic t_por();
    check(wd_state, wwd_pkg::wwd_por);
    wait_st(wwd_pkg::wwd_lead);
    check(32'(n > 17 && n < 23), 1);
    check(reset_n_oe, 0);
    host.pulse(5);
    repeat (12) @(negedge core_clk);
    check(wd_state, wwd_pkg::wwd_lead);
    $display("t_por done");
  endtask
  task automatic t_windows();
    host.pulse(8);
    wait_st(wwd_pkg::wwd_closed);
    check(32'(n < 14), 1);
    wait_st(wwd_pkg::wwd_open);
    check(32'(n > 2102 && n < 2110), 1);
    repeat (200) @(negedge core_clk);
    host.pulse(8);
    wait_st(wwd_pkg::wwd_closed);
    check(32'(n < 14), 1);
    wait_st(wwd_pkg::wwd_open);
    wait_st(wwd_pkg::wwd_fault);
    check(32'(n > 2206 && n < 2214), 1);
    @(negedge core_clk);
    check(reset_n_oe, 1);
    wait_st(wwd_pkg::wwd_lead);
    check(32'(n > 16 && n < 23), 1);
    wait_st(wwd_pkg::wwd_fault);
    check(32'(n > 15784 && n < 15796), 1);
    $display("t_windows done");
  endtask
  task automatic t_closed();
    mode.fail_safe = 1'b1;
    wait_st(wwd_pkg::wwd_lead);
    host.pulse(8);
    repeat (100) @(negedge core_clk);
    host.pulse(8);
    wait_st(wwd_pkg::wwd_fault);
    check(32'(n < 14), 1);
    @(negedge core_clk);
    check({src_txd_high, src_rxd_high}, 2'b11);
    wait_st(wwd_pkg::wwd_lead);
    check({src_txd_high, src_rxd_high}, 2'b00);
    mode.fail_safe = 1'b0;
    $display("t_closed done");
  endtask
  task automatic t_power();
    mode.low_power = 1'b1;
    repeat (2) @(negedge core_clk);
    check(wd_state, wwd_pkg::wwd_off);
    mode.low_power = 1'b0;
    repeat (20) @(negedge core_clk);
    check(wd_state, wwd_pkg::wwd_off);
    mode.rxd_fall = 1'b1;
    @(negedge core_clk);
    mode.rxd_fall = 1'b0;
    wait_st(wwd_pkg::wwd_lead);
    check(32'(n < 4), 1);
    mode.uv_reset = 1'b1;
    repeat (2) @(negedge core_clk);
    check(wd_state, wwd_pkg::wwd_por);
    mode.uv_reset = 1'b0;
    wait_st(wwd_pkg::wwd_lead);
    check(32'(n < 23), 1);
    $display("t_power done");
  endtask
  task automatic t_pin();
    clk_en = 1'b0;
    host.pulse(8);
    repeat (20) @(negedge core_clk);
    check(wd_state, wwd_pkg::wwd_lead);
    clk_en = 1'b1;
    repeat (12) @(negedge core_clk);
    check(wd_state, wwd_pkg::wwd_lead);
    pin = wwd_pkg::wwd_pin_short;
    wait_st(wwd_pkg::wwd_fault);
    check(32'(n > 195 && n < 205), 1);
    wait_st(wwd_pkg::wwd_lead);
    pin = wwd_pkg::wwd_pin_open;
    wait_st(wwd_pkg::wwd_fault);
    check(32'(n > 395 && n < 405), 1);
    pin = wwd_pkg::wwd_pin_ok;
    wait_st(wwd_pkg::wwd_lead);
    $display("t_pin done");
  endtask
  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    t_por();
    t_windows();
    t_closed();
    t_power();
    t_pin();
    stop_test();
  end
endmodule // testbench
